// ==== verilog/avc_pkg.sv ====
package avc_pkg;
    // Register offsets
    localparam logic [7:0] OFS_PATH_CTRL = 8'h11;
    localparam logic [7:0] OFS_IN_FLOOR = 8'h12;
    localparam logic [7:0] OFS_IN_FULL = 8'h13;
    localparam logic [7:0] OFS_DRV_FLOOR = 8'h14;
    localparam logic [7:0] OFS_DRV_CEIL = 8'h15;
    localparam logic [7:0] OFS_NOMINAL = 8'h16;
    localparam logic [7:0] OFS_CAL_BEMF = 8'h19;
    // Control register fields
    localparam int PEAK_LSB = 2;
    localparam int CUTOFF_LSB = 0;
    localparam int RSVD_LSB = 4;
    // Reset values
    localparam logic [1:0] RST_PEAK = 2'h1;
    localparam logic [1:0] RST_CUTOFF = 2'h1;
    localparam logic [7:0] RST_IN_FLOOR = 8'h19;
    localparam logic [7:0] RST_IN_FULL = 8'hff;
    localparam logic [7:0] RST_DRV_FLOOR = 8'h19;
    localparam logic [7:0] RST_DRV_CEIL = 8'hff;
    localparam logic [7:0] RST_NOMINAL = 8'h3e;
    localparam logic [7:0] RST_CAL_BEMF = 8'h6f;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
endpackage

// ==== verilog/avc_reset_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module avc_reset_sync (
    input wire logic ref_clk,
    input wire logic rstn,
    output logic rst_n_sync
);
    logic stage_reg;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            stage_reg <= 1'b1;
            rst_n_sync <= stage_reg;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/avc_config_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - Peak window field bits 3:2, reset 1
// - Cutoff field bits 1:0, reset 1
// - Inputs below floor are ignored, reset 0x19
// - Full-scale input code, reset 0xff
// - Drive not below floor code unless floor exceeds ceiling, reset 0x19
// - Drive never above ceiling code, reset 0xff
// - Closed loop uses nominal level, reset 0x3e
// - Open loop uses overdrive level instead
// - Calibration stores back-EMF result, 8 bits
module avc_config_regs (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic closed_loop,
    input wire logic [7:0] overdrive_clamp_level,
    input wire logic audio_amp_valid,
    input wire logic [7:0] audio_amp,
    input wire logic cal_done,
    input wire logic [7:0] cal_backemf,
    output logic [1:0] peak_window_sel,
    output logic [1:0] lowpass_cutoff_sel,
    output logic [7:0] input_floor_level,
    output logic [7:0] input_full_scale_level,
    output logic [7:0] drive_floor_level,
    output logic [7:0] drive_ceiling_level,
    output logic [7:0] actuator_nominal_reg,
    output logic [7:0] calibrated_backemf_level,
    output logic [7:0] full_scale_ref,
    output logic audio_drive_valid,
    output logic [7:0] audio_drive_level,
    output logic cal_stale
);
    logic rst_n_sync;

    avc_reset_sync u_reset_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .rst_n_sync(rst_n_sync)
    );

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] t;
        t = (v < lo) ? lo : v;
        clamp = (t > hi) ? hi : t;
    endfunction

    logic wr_ctrl;
    logic wr_nominal;
    assign wr_ctrl = reg_wr_en && hit(reg_addr, avc_pkg::OFS_PATH_CTRL);
    assign wr_nominal = reg_wr_en && hit(reg_addr, avc_pkg::OFS_NOMINAL);

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            peak_window_sel <= avc_pkg::RST_PEAK;
            lowpass_cutoff_sel <= avc_pkg::RST_CUTOFF;
        end else if (wr_ctrl) begin
            peak_window_sel <= reg_wdata[avc_pkg::PEAK_LSB +: 2];
            lowpass_cutoff_sel <= reg_wdata[avc_pkg::CUTOFF_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level registers
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            input_floor_level <= avc_pkg::RST_IN_FLOOR;
            input_full_scale_level <= avc_pkg::RST_IN_FULL;
            drive_floor_level <= avc_pkg::RST_DRV_FLOOR;
            drive_ceiling_level <= avc_pkg::RST_DRV_CEIL;
            actuator_nominal_reg <= avc_pkg::RST_NOMINAL;
        end else if (reg_wr_en) begin
            if (hit(reg_addr, avc_pkg::OFS_IN_FLOOR)) begin
                input_floor_level <= reg_wdata;
            end
            if (hit(reg_addr, avc_pkg::OFS_IN_FULL)) begin
                input_full_scale_level <= reg_wdata;
            end
            if (hit(reg_addr, avc_pkg::OFS_DRV_FLOOR)) begin
                drive_floor_level <= reg_wdata;
            end
            if (hit(reg_addr, avc_pkg::OFS_DRV_CEIL)) begin
                drive_ceiling_level <= reg_wdata;
            end
            if (wr_nominal) begin
                actuator_nominal_reg <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration result, hardware update beats host write
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            calibrated_backemf_level <= avc_pkg::RST_CAL_BEMF;
        end else if (cal_done) begin
            calibrated_backemf_level <= cal_backemf;
        end else if (reg_wr_en && hit(reg_addr, avc_pkg::OFS_CAL_BEMF)) begin
            calibrated_backemf_level <= reg_wdata;
        end
    end

    // Stale result flag, a nominal write beats a finishing calibration
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cal_stale <= 1'b0;
        end else if (wr_nominal) begin
            cal_stale <= 1'b1;
        end else if (cal_done) begin
            cal_stale <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Full-scale reference select
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            full_scale_ref <= avc_pkg::RST_NOMINAL;
        end else if (closed_loop) begin
            full_scale_ref <= actuator_nominal_reg;
        end else begin
            full_scale_ref <= overdrive_clamp_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Audio amplitude to drive level
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            audio_drive_valid <= 1'b0;
            audio_drive_level <= 8'h00;
        end else begin
            audio_drive_valid <= audio_amp_valid && (audio_amp >= input_floor_level);
            if (audio_amp_valid && audio_amp >= input_full_scale_level && audio_amp >= input_floor_level) begin
                audio_drive_level <= clamp(drive_ceiling_level, drive_floor_level,
                                           drive_ceiling_level);
            end else if (audio_amp_valid && audio_amp >= input_floor_level) begin
                audio_drive_level <= clamp(audio_amp, drive_floor_level,
                                           drive_ceiling_level);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge ref_clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                unique case (reg_addr)
                    avc_pkg::OFS_PATH_CTRL: begin
                        reg_rdata <= {4'h0, peak_window_sel, lowpass_cutoff_sel};
                    end
                    avc_pkg::OFS_IN_FLOOR: begin
                        reg_rdata <= input_floor_level;
                    end
                    avc_pkg::OFS_IN_FULL: begin
                        reg_rdata <= input_full_scale_level;
                    end
                    avc_pkg::OFS_DRV_FLOOR: begin
                        reg_rdata <= drive_floor_level;
                    end
                    avc_pkg::OFS_DRV_CEIL: begin
                        reg_rdata <= drive_ceiling_level;
                    end
                    avc_pkg::OFS_NOMINAL: begin
                        reg_rdata <= actuator_nominal_reg;
                    end
                    avc_pkg::OFS_CAL_BEMF: begin
                        reg_rdata <= calibrated_backemf_level;
                    end
                    default: begin
                        reg_rdata <= avc_pkg::UNMAPPED_DATA;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_peak_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        wr_ctrl |=> peak_window_sel == $past(reg_wdata[3:2]);
    endproperty
    a_peak_write: assert property (p_peak_write) else $error("peak window not written");

    property p_cutoff_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        wr_ctrl |=> lowpass_cutoff_sel == $past(reg_wdata[1:0]);
    endproperty
    a_cutoff_write: assert property (p_cutoff_write) else $error("cutoff not written");

    property p_floor_ignore;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (audio_amp_valid && audio_amp < input_floor_level)
        |=> !audio_drive_valid && audio_drive_level == $past(audio_drive_level);
    endproperty
    a_floor_ignore: assert property (p_floor_ignore) else $error("sub-floor input drove");

    property p_full_scale;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (audio_amp_valid && audio_amp >= input_full_scale_level && audio_amp >= input_floor_level
         && drive_floor_level <= drive_ceiling_level)
        |=> audio_drive_valid && audio_drive_level == $past(drive_ceiling_level);
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale not at ceiling");

    property p_drive_min;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (audio_drive_valid && drive_floor_level <= drive_ceiling_level && $stable(drive_floor_level)
         && $stable(drive_ceiling_level)) |-> audio_drive_level >= drive_floor_level;
    endproperty
    a_drive_min: assert property (p_drive_min) else $error("drive below floor");

    property p_drive_max;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (audio_drive_valid && $stable(drive_ceiling_level)) |-> audio_drive_level <= drive_ceiling_level;
    endproperty
    a_drive_max: assert property (p_drive_max) else $error("drive above ceiling");

    property p_closed_ref;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (rst_n_sync && closed_loop) |=> full_scale_ref == $past(actuator_nominal_reg);
    endproperty
    a_closed_ref: assert property (p_closed_ref) else $error("closed loop reference wrong");

    property p_open_ref;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (rst_n_sync && !closed_loop) |=> full_scale_ref == $past(overdrive_clamp_level);
    endproperty
    a_open_ref: assert property (p_open_ref) else $error("open loop reference wrong");

    property p_stale;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        wr_nominal ##1 (!wr_nominal && !cal_done) [*2] |-> cal_stale;
    endproperty
    a_stale: assert property (p_stale) else $error("stale flag lost");

    property p_cal_store;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        cal_done |=> calibrated_backemf_level == $past(cal_backemf) && !(cal_stale && !$past(wr_nominal));
    endproperty
    a_cal_store: assert property (p_cal_store) else $error("calibration result not stored");

    property p_reserved;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (reg_rd_en && reg_addr == avc_pkg::OFS_PATH_CTRL) |=> reg_rd_valid && reg_rdata[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_floor_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (reg_wr_en && reg_addr == avc_pkg::OFS_IN_FLOOR) |=> input_floor_level == $past(reg_wdata);
    endproperty
    a_floor_write: assert property (p_floor_write) else $error("input floor not written");

    property p_full_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (reg_wr_en && reg_addr == avc_pkg::OFS_IN_FULL) |=> input_full_scale_level == $past(reg_wdata);
    endproperty
    a_full_write: assert property (p_full_write) else $error("input full scale not written");

    property p_drv_floor_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (reg_wr_en && reg_addr == avc_pkg::OFS_DRV_FLOOR) |=> drive_floor_level == $past(reg_wdata);
    endproperty
    a_drv_floor_write: assert property (p_drv_floor_write) else $error("drive floor not written");

    property p_drv_ceil_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (reg_wr_en && reg_addr == avc_pkg::OFS_DRV_CEIL) |=> drive_ceiling_level == $past(reg_wdata);
    endproperty
    a_drv_ceil_write: assert property (p_drv_ceil_write) else $error("drive ceiling not written");

    property p_nominal_write;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        wr_nominal |=> actuator_nominal_reg == $past(reg_wdata);
    endproperty
    a_nominal_write: assert property (p_nominal_write) else $error("nominal level not written");

    property p_stale_clear;
        @(posedge ref_clk) disable iff (!rst_n_sync)
        (cal_done && !wr_nominal) |=> !cal_stale;
    endproperty
    a_stale_clear: assert property (p_stale_clear) else $error("stale flag not cleared");
endmodule
`default_nettype wire

// ==== test/avc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module avc_host_model (
    input wire logic ref_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Single write, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Single read, data and valid one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd_en <= 1'b0;
        #1;
        d = reg_rdata;
        v = reg_rd_valid;
    endtask
endmodule
`default_nettype wire

// ==== test/audio_vibe_config_regs_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module audio_vibe_config_regs_tb_top;
    logic ref_clk, rstn, wr, rde, rdv, cl, av, cd, dv, stale;
    logic [7:0] ad, wd, rdat, od, amp, cb, fl, fs, dfl, dce, nom, lvl, d, exp_lvl;
    logic [1:0] pk, lp;
    logic [7:0] o_fl, o_fs, o_dfl, o_dce, o_nom, o_cal, fsr;
    logic v;
    logic [7:0] rnd;
    int error_cnt, cmp_count, i;
    logic [7:0] adr [8] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h19, 8'h10};
    logic [7:0] rv [8] = '{8'h05, 8'h19, 8'hff, 8'h19, 8'hff, 8'h3e, 8'h6f, 8'h00};
    ////////////////////////////////////////////////////////////
    avc_config_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_wr_en(wr), .reg_rd_en(rde), .reg_addr(ad),
        .reg_wdata(wd), .reg_rdata(rdat), .reg_rd_valid(rdv), .closed_loop(cl), .overdrive_clamp_level(od),
        .audio_amp_valid(av), .audio_amp(amp), .cal_done(cd), .cal_backemf(cb), .peak_window_sel(pk),
        .lowpass_cutoff_sel(lp), .input_floor_level(o_fl), .input_full_scale_level(o_fs),
        .drive_floor_level(o_dfl), .drive_ceiling_level(o_dce), .actuator_nominal_reg(o_nom),
        .calibrated_backemf_level(o_cal), .full_scale_ref(fsr), .audio_drive_valid(dv),
        .audio_drive_level(lvl), .cal_stale(stale));
    avc_host_model host (.ref_clk(ref_clk), .reg_wr_en(wr), .reg_rd_en(rde), .reg_addr(ad),
        .reg_wdata(wd), .reg_rdata(rdat), .reg_rd_valid(rdv));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Clamp to drive limits, ceiling last
    function automatic logic [7:0] drv_exp(input logic [7:0] a);
        logic [7:0] x;
        x = (a >= fs) ? dce : a;
        if (x < dfl) x = dfl;
        if (x > dce) x = dce;
        return x;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string m);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected t=%0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask
    task automatic send_amp(input logic [7:0] a);
        @(posedge ref_clk);
        av <= 1'b1;
        amp <= a;
        @(posedge ref_clk);
        av <= 1'b0;
        amp <= ~a;
        #1;
        if (a >= fl) exp_lvl = drv_exp(a);
        chk({7'h00, dv}, {7'h00, a >= fl}, "drive valid");
        chk(lvl, exp_lvl, "drive level");
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        rstn = 1'b0;
        cl = 1'b1;
        od = 8'h8c;
        av = 1'b0;
        amp = 8'h00;
        cd = 1'b0;
        cb = 8'h00;
        error_cnt = 0;
        cmp_count = 0;
        rnd = 8'h36;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        chk(fsr, 8'h3e, "fs ref reset");
        for (i = 0; i < 8; i++) begin
            host.rd(adr[i], d, v);
            chk(d, rv[i], "reset value");
            chk({7'h00, v}, 8'h01, "read valid");
        end
        // Write and read back, reserved and unmapped included
        for (i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            host.wr(adr[i], rnd);
            #1;
            if (i == 0) chk({4'h0, pk, lp}, {4'h0, rnd[3:0]}, "ctrl fields");
            host.rd(adr[i], d, v);
            chk(d, (i == 0) ? {4'h0, rnd[3:0]} : (i == 7) ? 8'h00 : rnd, "readback");
        end
        // Random audio limits with floor corners
        for (i = 0; i < 10; i++) begin
            fl = lfsr(rnd);
            fs = lfsr(fl);
            dfl = lfsr(fs);
            dce = lfsr(dfl);
            rnd = dce;
            host.wr(8'h12, fl);
            host.wr(8'h13, fs);
            host.wr(8'h14, dfl);
            host.wr(8'h15, dce);
            #1;
            chk(o_fl, fl, "floor port");
            chk(o_fs, fs, "full scale port");
            chk(o_dfl, dfl, "drive floor port");
            chk(o_dce, dce, "drive ceiling port");
            send_amp(fl);
            rnd = lfsr(rnd);
            send_amp(rnd);
            send_amp(fs);
            if (fl != 8'h00) send_amp(fl - 8'h01);
        end
        // Clear stale flag left by the write loop
        @(posedge ref_clk);
        cd <= 1'b1;
        @(posedge ref_clk);
        cd <= 1'b0;
        #1;
        chk({7'h00, stale}, 8'h00, "stale clear first");
        chk(o_cal, 8'h00, "cal result first");
        // Calibration after nominal write
        nom = lfsr(rnd);
        host.wr(8'h16, nom);
        #1;
        chk({7'h00, stale}, 8'h01, "stale set");
        chk(o_nom, nom, "nominal port");
        @(posedge ref_clk);
        cd <= 1'b1;
        cb <= ~nom;
        @(posedge ref_clk);
        cd <= 1'b0;
        cb <= nom;
        #1;
        chk(o_cal, ~nom, "cal result");
        chk({7'h00, stale}, 8'h00, "stale clear");
        host.rd(8'h19, d, v);
        chk(d, ~nom, "cal readback");
        // Full-scale reference per loop mode
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            @(posedge ref_clk);
            cl <= i[0];
            od <= rnd;
            repeat (2) @(posedge ref_clk);
            #1;
            chk(fsr, i[0] ? nom : rnd, "fs ref");
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
